// ---- cpsf_defines.vh ----
/*
  constants for the processor status register block.
  assumes inclusion by bare name from the design file.
*/
`ifndef CPSF_DEFINES_VH
`define CPSF_DEFINES_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define CPSF_IDX_STATUS   8'h03
`define CPSF_IDX_OPCTL    8'h04
`define CPSF_IDX_OPERAND  8'h05
`define CPSF_IDX_RESULT   8'h06
`define CPSF_IDX_EVENT    8'h07
// ----------------------------------------
// field positions
// ----------------------------------------
`define CPSF_BIT_C    0
`define CPSF_BIT_DC   1
`define CPSF_BIT_Z    2
`define CPSF_BIT_PD   3
`define CPSF_BIT_TO   4
`define CPSF_BIT_RP0  5
`define CPSF_BIT_RP1  6
`define CPSF_BIT_IRP  7
// ----------------------------------------
// operation codes
// ----------------------------------------
`define CPSF_OP_MOVE   4'h0
`define CPSF_OP_CLR    4'h1
`define CPSF_OP_BCF    4'h2
`define CPSF_OP_BSF    4'h3
`define CPSF_OP_SWAP   4'h4
`define CPSF_OP_ADD    4'h5
`define CPSF_OP_SUB    4'h6
`define CPSF_OP_AND    4'h7
`define CPSF_OP_RLF    4'h8
`define CPSF_OP_RRF    4'h9
// ----------------------------------------
// reset values
// ----------------------------------------
`define CPSF_RST_STATUS  8'h18
`endif

// ---- cpsf_status_reg.v ----
/*
  processor status register with a small alu front end, reached over apb.
  assumes a single clock, synchronous inputs and an apb master that holds
  each request until pready.
*/
// What this block does
// (RQ1) status register accepts writes like any file
// (RQ2) flag-updating ops load z, dc, c from alu
// (RQ3) writes to reset-cause bits are ignored
// (RQ4) clear op clears top three, sets zero
// (RQ5) bit, swap, move ops keep alu flags
// (RQ6) top two bits unused, never decoded
// (RQ7) subtract adds two's complement; borrows inverted
// (RQ8) cleared carry means a borrow occurred
// (RQ9) rotate loads carry from msb or lsb
// (RQ10) reset-cause bits follow power-up, watchdog, sleep
// (RQ11) bank bit selects bank; zero on zero result
`timescale 1ns/1ps
`include "cpsf_defines.vh"

module cpsf_status_reg (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // reset-cause events from the core
  input  wire        watchdogTimeout,
  input  wire        sleepEntry,
  input  wire        watchdogClear,
  // status seen by the core
  output reg  [7:0]  statusOut,
  output reg         bankSelect
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function [7:0] regIndex;
    input [11:0] addr;
    begin
      regIndex = addr[9:2];
    end
  endfunction

  function wordAligned;
    input [11:0] addr;
    begin
      wordAligned = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0] status_q;
  reg  [7:0] status_d;
  reg  [7:0] operand_q;
  reg  [7:0] result_q;
  reg  [7:0] result_d;
  reg  [7:0] opctl_q;
  reg        powerUp_q;
  reg  [7:0] rdMux;
  reg        err;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // the registered pready blocks a second take of one access
  wire       access    = psel && penable && !pready;
  wire       wrStrobe  = access && pwrite;
  wire [7:0] idx       = regIndex(paddr);
  wire       aligned   = wordAligned(paddr);
  wire       opStrobe  = wrStrobe && aligned && (idx == `CPSF_IDX_OPCTL);
  wire       statWrite = wrStrobe && aligned && (idx == `CPSF_IDX_STATUS);
  wire       evtWrite  = wrStrobe && aligned && (idx == `CPSF_IDX_EVENT);
  wire [3:0] opCode    = pwdata[3:0];
  wire [2:0] bitSel    = pwdata[6:4];
  wire       destStat  = pwdata[7];
  wire       operandWrite = wrStrobe && aligned && (idx == `CPSF_IDX_OPERAND);

  // ----------------------------------------
  // reset-cause events
  // ----------------------------------------
  // the event register replays a core event, useful before the core exists
  wire       setRun     = powerUp_q || watchdogClear || (evtWrite && pwdata[2]);
  wire       setSleep   = sleepEntry || (evtWrite && pwdata[1]);
  wire       setTimeout = watchdogTimeout || (evtWrite && pwdata[0]);

  // ----------------------------------------
  // alu
  // ----------------------------------------
  // source operand is the status register itself when it is the destination
  wire [7:0] src       = destStat ? status_q : operand_q;
  wire [7:0] accum     = pwdata[15:8];
  // subtract reuses the adder, so carry out reads as not-borrow
  wire [7:0] subB      = ~accum;
  wire [8:0] addSum    = {1'b0, src} + {1'b0, accum};
  wire [8:0] subSum    = {1'b0, src} + {1'b0, subB} + 9'h001; // RQ7
  wire [4:0] addNib    = {1'b0, src[3:0]} + {1'b0, accum[3:0]};
  wire [4:0] subNib    = {1'b0, src[3:0]} + {1'b0, subB[3:0]} + 5'h01; // RQ7

  reg  [7:0] aluRes;
  reg        updZ;
  reg        updDc;
  reg        updC;
  reg        newZ;
  reg        newDc;
  reg        newC;

  always @* begin
    aluRes = src;
    updZ   = 1'b0;
    updDc  = 1'b0;
    updC   = 1'b0;
    newDc  = status_q[`CPSF_BIT_DC];
    newC   = status_q[`CPSF_BIT_C];
    case (opCode)
      `CPSF_OP_MOVE: begin
        aluRes = accum; // RQ5
      end
      `CPSF_OP_CLR: begin
        aluRes = 8'h00;
        updZ   = 1'b1; // RQ4
        // dc and c take their own old value, so a clear leaves them alone
        updDc  = 1'b1; // RQ4
        updC   = 1'b1; // RQ4
      end
      `CPSF_OP_BCF: begin
        aluRes = src & ~(8'h01 << bitSel); // RQ5
      end
      `CPSF_OP_BSF: begin
        aluRes = src | (8'h01 << bitSel); // RQ5
      end
      `CPSF_OP_SWAP: begin
        aluRes = {src[3:0], src[7:4]}; // RQ5
      end
      `CPSF_OP_ADD: begin
        aluRes = addSum[7:0];
        updZ   = 1'b1;
        updDc  = 1'b1;
        updC   = 1'b1;
        newDc  = addNib[4];
        newC   = addSum[8];
      end
      `CPSF_OP_SUB: begin
        aluRes = subSum[7:0];
        updZ   = 1'b1;
        updDc  = 1'b1;
        updC   = 1'b1;
        newDc  = subNib[4]; // RQ7
        newC   = subSum[8]; // RQ8
      end
      `CPSF_OP_AND: begin
        aluRes = src & accum;
        updZ   = 1'b1;
      end
      // rotates run through the carry flag
      `CPSF_OP_RLF: begin
        aluRes = {src[6:0], status_q[`CPSF_BIT_C]};
        updC   = 1'b1;
        newC   = src[7]; // RQ9
      end
      `CPSF_OP_RRF: begin
        aluRes = {status_q[`CPSF_BIT_C], src[7:1]};
        updC   = 1'b1;
        newC   = src[0]; // RQ9
      end
      default: begin
        aluRes = src;
      end
    endcase
    newZ = (aluRes == 8'h00); // RQ11
  end

  // ----------------------------------------
  // next status value
  // ----------------------------------------
  always @* begin
    status_d = status_q;
    result_d = result_q;
    // one bus, so an op and a direct write never meet
    if (opStrobe) begin
      result_d = aluRes;
      if (destStat) begin
        // writable bits take the result; reset-cause bits stay
        status_d[`CPSF_BIT_IRP] = aluRes[`CPSF_BIT_IRP]; // RQ1
        status_d[`CPSF_BIT_RP1] = aluRes[`CPSF_BIT_RP1]; // RQ1
        status_d[`CPSF_BIT_RP0] = aluRes[`CPSF_BIT_RP0]; // RQ4
        if (!updZ) status_d[`CPSF_BIT_Z] = aluRes[`CPSF_BIT_Z];
        if (!updDc) status_d[`CPSF_BIT_DC] = aluRes[`CPSF_BIT_DC];
        if (!updC) status_d[`CPSF_BIT_C] = aluRes[`CPSF_BIT_C];
      end
      if (updZ) status_d[`CPSF_BIT_Z] = newZ; // RQ2
      if (updDc) status_d[`CPSF_BIT_DC] = newDc; // RQ2
      if (updC) status_d[`CPSF_BIT_C] = newC; // RQ2
    end else if (statWrite) begin // RQ3
      // bits 4 and 3 are left out, so a status write never moves them
      status_d[`CPSF_BIT_IRP] = pwdata[`CPSF_BIT_IRP]; // RQ1
      status_d[`CPSF_BIT_RP1] = pwdata[`CPSF_BIT_RP1]; // RQ1
      status_d[`CPSF_BIT_RP0] = pwdata[`CPSF_BIT_RP0]; // RQ1
      status_d[2:0]           = pwdata[2:0]; // RQ1
    end
    // reset-cause bits move only by their own events
    if (setRun) begin
      status_d[`CPSF_BIT_TO] = 1'b1; // RQ10
      status_d[`CPSF_BIT_PD] = 1'b1; // RQ10
    end
    if (setSleep) begin
      status_d[`CPSF_BIT_TO] = 1'b1; // RQ10
      status_d[`CPSF_BIT_PD] = 1'b0; // RQ10
    end
    // timeout is the latest event in a cycle, so it wins
    if (setTimeout) begin
      status_d[`CPSF_BIT_TO] = 1'b0; // RQ10
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rdMux = 8'h00;
    err   = 1'b0;
    if (!aligned) begin
      err = 1'b1;
    end else if (idx == `CPSF_IDX_STATUS) begin
      rdMux = status_q;
    end else if (idx == `CPSF_IDX_OPCTL) begin
      rdMux = opctl_q;
    end else if (idx == `CPSF_IDX_OPERAND) begin
      rdMux = operand_q;
    end else if (idx == `CPSF_IDX_RESULT) begin
      rdMux = result_q;
    end else if (idx == `CPSF_IDX_EVENT) begin
      // event register is write-only and reads back as zero
      rdMux = 8'h00;
    end else begin
      err = 1'b1;
    end
  end

  // ----------------------------------------
  // status and result registers
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_q   <= `CPSF_RST_STATUS;
      result_q   <= 8'h00;
      powerUp_q  <= 1'b1;
      statusOut  <= `CPSF_RST_STATUS;
      bankSelect <= 1'b0;
    end else begin
      powerUp_q  <= 1'b0;
      status_q   <= status_d;
      result_q   <= result_d;
      // copy taken from the next value so the core sees it with status_q
      statusOut  <= status_d;
      // only the low bank bit is decoded; the top two are ignored
      bankSelect <= status_d[`CPSF_BIT_RP0]; // RQ11 RQ6
    end
  end

  // ----------------------------------------
  // operand file and op control
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      operand_q <= 8'h00;
      opctl_q   <= 8'h00;
    end else begin
      if (opStrobe) begin
        opctl_q <= pwdata[7:0];
      end
      if (operandWrite) begin
        operand_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  // one wait state on every access keeps the answer a plain register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && err;
      prdata  <= (access && !pwrite && !err) ? {24'h000000, rdMux} : 32'h00000000;
    end
  end

endmodule

// ---- cpsf_status_monitor.sv ----
/*
  port checker for the processor status register block.
  assumes one clock domain and an async, active-high rst.
*/
`timescale 1ns/1ps
module cpsf_status_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // core side
  input wire logic        watchdogTimeout,
  input wire logic        sleepEntry,
  input wire logic        watchdogClear,
  input wire logic [7:0]  statusOut,
  input wire logic        bankSelect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_take; psel && penable && !pready |=> pready; endproperty
  property p_idle; !(psel && penable) |=> !pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  property p_bank; bankSelect == statusOut[5]; endproperty
  property p_tmo; watchdogTimeout |=> !statusOut[4]; endproperty
  property p_slp; sleepEntry && !watchdogTimeout |=> statusOut[4:3] == 2'b10; endproperty
  property p_wdc; watchdogClear && !sleepEntry && !watchdogTimeout |=> statusOut[4:3] == 2'b11; endproperty
  // with no psel and no core event the reset-cause bits must never move
  property p_hold; !(psel || watchdogTimeout || sleepEntry || watchdogClear) |=> $stable(statusOut[4:3]);
  endproperty
  // a direct status write must leave the reset-cause bits as they were
  property p_stw; psel && penable && !pready && pwrite && paddr == 12'h00C &&
    !(watchdogTimeout || sleepEntry || watchdogClear) |=> $stable(statusOut[4:3]); endproperty
  a_take: assert property (p_take) else $error("access not answered");
  a_idle: assert property (p_idle) else $error("ready without access");
  a_once: assert property (p_once) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_rdz: assert property (p_rdz) else $error("read data outside ready");
  a_bank: assert property (p_bank) else $error("bank select differs from bit 5");
  a_tmo: assert property (p_tmo) else $error("timeout bit not cleared");
  a_slp: assert property (p_slp) else $error("sleep cause bits wrong");
  a_wdc: assert property (p_wdc) else $error("watchdog clear cause bits wrong");
  a_hold: assert property (p_hold) else $error("cause bits moved without event");
  a_stw: assert property (p_stw) else $error("status write moved cause bits");
  c_err: cover property (pslverr);
  c_tmo: cover property (watchdogTimeout);
  c_slp: cover property (sleepEntry);
endmodule
bind cpsf_status_reg cpsf_status_monitor mon_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .watchdogTimeout(watchdogTimeout), .sleepEntry(sleepEntry),
  .watchdogClear(watchdogClear), .statusOut(statusOut), .bankSelect(bankSelect));

// ---- cpsf_core_model.sv ----
/*
  core model raising reset-cause events.
  assumes callers wait for one pulse to end before the next.
*/
`timescale 1ns/1ps
module cpsf_core_model (
  // clock
  input  wire logic clk_sys,
  // events
  output logic      watchdogTimeout,
  output logic      sleepEntry,
  output logic      watchdogClear
);
  initial {watchdogClear, sleepEntry, watchdogTimeout} = 3'h0;
  // single-cycle pulse, one event kind at a time
  task automatic pulse(input logic [2:0] ev);
    @(posedge clk_sys);
    {watchdogClear, sleepEntry, watchdogTimeout} <= ev;
    @(posedge clk_sys);
    {watchdogClear, sleepEntry, watchdogTimeout} <= 3'h0;
  endtask
endmodule

// ---- cpu_status_flags_register_tb.sv ----
/*
  testbench for the processor status register block.
  assumes the apb map of the design; waits on pready, not a fixed count.
*/
`timescale 1ns/1ps
`include "cpsf_defines.vh"
module cpu_status_flags_register_tb;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rdat;
  logic [7:0]  statusOut;
  logic        pready, pslverr, rerr, wdt, slp, wdc, bankSelect;
  int          err_total = 0;
  int          tests_run = 0;
  localparam logic [11:0] ST  = {2'h0, `CPSF_IDX_STATUS, 2'h0};
  localparam logic [11:0] OPC = {2'h0, `CPSF_IDX_OPCTL, 2'h0};
  localparam logic [11:0] OPN = {2'h0, `CPSF_IDX_OPERAND, 2'h0};
  localparam logic [11:0] RES = {2'h0, `CPSF_IDX_RESULT, 2'h0};
  localparam logic [11:0] EVT = {2'h0, `CPSF_IDX_EVENT, 2'h0};
  logic [15:0] opv [4] = '{16'h0081, 16'h2380, 16'h0082, 16'h00A3};
  logic [31:0] stv [4] = '{32'h17, 32'h33, 32'h32, 32'h36};
  always #5 clk_sys = ~clk_sys;
  cpsf_status_reg dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .watchdogTimeout(wdt), .sleepEntry(slp), .watchdogClear(wdc),
    .statusOut(statusOut), .bankSelect(bankSelect));
  cpsf_core_model core_u (.clk_sys(clk_sys), .watchdogTimeout(wdt), .sleepEntry(slp),
    .watchdogClear(wdc));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a spare edge first so a released strobe is never reasserted in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20)
      err_total++;
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  initial begin
    #20us;
    err_total++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ST, 32'h18, 32'hFF);
    core_u.pulse(3'h2);
    rd(ST, 32'h10, 32'hFF);
    apb(1'b1, ST, 32'hFF);
    rd(ST, 32'hF7, 32'hFF);
    chk({31'h0, bankSelect}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OPC, {16'h0, opv[i]});
      rd(ST, stv[i], 32'hFF);
    end
    apb(1'b1, OPN, 32'h05);
    apb(1'b1, OPC, 32'h0606);
    rd(ST, 32'h30, 32'hFF);
    rd(RES, 32'hFF, 32'hFF);
    apb(1'b1, OPC, 32'h0506);
    rd(ST, 32'h37, 32'hFF);
    apb(1'b1, OPN, 32'h81);
    apb(1'b1, OPC, 32'h08);
    rd(RES, 32'h03, 32'hFF);
    rd(ST, 32'h01, 32'h01);
    apb(1'b1, OPN, 32'h02);
    apb(1'b1, OPC, 32'h09);
    rd(RES, 32'h81, 32'hFF);
    rd(ST, 32'h00, 32'h01);
    apb(1'b1, OPN, 32'h88);
    apb(1'b1, OPC, 32'h8805);
    rd(RES, 32'h10, 32'hFF);
    rd(ST, 32'h03, 32'h07);
    apb(1'b1, OPC, 32'h7707);
    rd(RES, 32'h00, 32'hFF);
    rd(ST, 32'h07, 32'h07);
    rd(OPC, 32'h07, 32'hFF);
    apb(1'b1, EVT, 32'h1);
    rd(ST, 32'h00, 32'h10);
    core_u.pulse(3'h4);
    core_u.pulse(3'h1);
    rd(ST, 32'h08, 32'h18);
    core_u.pulse(3'h4);
    apb(1'b1, ST, 32'hC0);
    rd(ST, 32'hD8, 32'hFF);
    chk({24'h0, statusOut}, 32'hD8);
    chk({31'h0, bankSelect}, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, 12'h00D, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ST, 32'h18, 32'hFF);
    chk({31'h0, bankSelect}, 32'h0);
    end_of_test;
  end
endmodule
